// [hdl/drs_sequencer.sv]
// Dual ramp converter sequencer with Avalon-MM register slave and interrupt.
// Assumes an external integrator, comparator and reference driven by rampSelectOutput.
//
// Summary of operation
// - Convert in two phases: fixed integrate of input, then reference until threshold.
// - Steps counted during reference de-integration form the raw value.
// - Comparator reports integrator level; ramp-select routes input or reference.
// - Subtract 512 offset counts so a zero input reads zero.
// - Result is 12 bits, split into upper four and lower eight.
// - Before starting, hold ramp-select high until comparator shows below threshold.
// - Once integrator is low, raise conversion-finished to show readiness.
// - Idle until cycle request; then clear finished and drop ramp-select.
// - Load ramp-up counter with 2000 hex, decrement once per step.
// - Start decrementing only after comparator goes low to high.
// - At zero raise ramp-select, then increment per step until threshold returns.
// - Ramp-down step lasts twice the ramp-up step.
// - Result above 4095 raises overrange with finished and ramp-select high.
// - In range, raise only finished and ramp-select, then await request.
// - Conversion time varies with input since de-integration ends on comparator.
// - Full-scale conversion takes about 165 ms at the reference timing.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer #(
    parameter int UP_STEP_CYC = drs_pkg::UP_STEP_CYC,
    parameter int DN_STEP_CYC = drs_pkg::DN_STEP_CYC,
    parameter int STEP_W      = drs_pkg::STEP_W
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        cycleRequestInput,
    input  wire logic        comparatorInput,
    output logic             rampSelectOutput,
    output logic             convFinished,
    output logic             overrange,
    output logic      [3:0]  resultHigh,
    output logic      [7:0]  resultLow,
    output logic             irq
);
    localparam logic [STEP_W-1:0] UP_LAST = STEP_W'(UP_STEP_CYC - 1);
    localparam logic [STEP_W-1:0] DN_LAST = STEP_W'(DN_STEP_CYC - 1);
    localparam logic [2:0]        SETTLE_LAST = 3'h4;   // Three pin stages plus the agreement stage

    drs_pkg::drs_state_t         state;
    logic [15:0]                 rampCount;
    logic [STEP_W-1:0]           stepCnt;
    logic                        stepEnd;
    logic                        comp;
    logic                        compPrev;
    logic [2:0]                  settleCnt;
    logic                        cycleReq;
    logic                        softReq;
    logic                        startReq;
    logic                        accWrite;
    logic [drs_pkg::IRQ_W-1:0]   irqStatus;
    logic [drs_pkg::IRQ_W-1:0]   irqEnable;
    logic [drs_pkg::IRQ_W-1:0]   irqEvent;
    logic [drs_pkg::IRQ_W-1:0]   irqClear;

    // Raw count minus offset; short counts floor at zero
    function automatic logic [15:0] offsetFix(input logic [15:0] cnt);
        if (cnt < drs_pkg::OFFSET_COUNTS) begin
            return 16'h0000;
        end
        return cnt - drs_pkg::OFFSET_COUNTS;
    endfunction

    // Corrected value beyond the 12-bit span
    function automatic logic isOver(input logic [15:0] cnt);
        return offsetFix(cnt) > drs_pkg::MAX_RESULT;
    endfunction

    // Pin synchronisation
    drs_pin_if pins ();
    assign pins.pinRaw[drs_pkg::PIN_COMP]  = comparatorInput;
    assign pins.pinRaw[drs_pkg::PIN_CYCLE] = cycleRequestInput;

    drs_pin_sync u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pins    (pins)
    );

    assign comp     = pins.pinClean[drs_pkg::PIN_COMP];   // High: integrator above level
    assign cycleReq = pins.pinClean[drs_pkg::PIN_CYCLE];
    assign startReq = cycleReq | softReq;

    // Step boundary; ramp-down steps are twice as long as ramp-up steps
    assign stepEnd = (state == drs_pkg::S_UP) ? (stepCnt == UP_LAST)
                                              : (stepCnt == DN_LAST);

    // Previous comparator level for the crossing detector
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            compPrev <= 1'b0;
        end else begin
            compPrev <= comp;
        end
    end

    // Pin chain fill time; the clean level resets low, which would pass the check too early
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            settleCnt <= 3'h0;
        end else if (settleCnt != SETTLE_LAST) begin
            settleCnt <= settleCnt + 3'h1;
        end
    end

    // Sequencer and the ramp-select and finished pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state            <= drs_pkg::S_CHECK;
            rampSelectOutput <= 1'b1;
            convFinished     <= 1'b0;
        end else begin
            case (state)
                drs_pkg::S_CHECK: begin
                    rampSelectOutput <= 1'b1;
                    if (!comp && settleCnt == SETTLE_LAST) begin
                        state        <= drs_pkg::S_READY;
                        convFinished <= 1'b1;
                    end
                end
                drs_pkg::S_READY: begin
                    if (startReq) begin
                        state            <= drs_pkg::S_CROSS;
                        convFinished     <= 1'b0;
                        rampSelectOutput <= 1'b0;
                    end
                end
                drs_pkg::S_CROSS: begin
                    if (comp && !compPrev) begin
                        state <= drs_pkg::S_UP;
                    end
                end
                drs_pkg::S_UP: begin
                    if (stepEnd && rampCount == 16'h0001) begin
                        state            <= drs_pkg::S_DOWN;
                        rampSelectOutput <= 1'b1;
                    end
                end
                drs_pkg::S_DOWN: begin
                    // Length follows the input: ends only on the comparator
                    if (stepEnd && !comp) begin
                        state <= drs_pkg::S_DONE;
                    end
                end
                drs_pkg::S_DONE: begin
                    state            <= drs_pkg::S_READY;
                    convFinished     <= 1'b1;
                    rampSelectOutput <= 1'b1;
                end
                default: begin
                    state            <= drs_pkg::S_CHECK;
                    rampSelectOutput <= 1'b1;
                end
            endcase
        end
    end

    // Step timer; idle outside the two ramps so each phase starts on a full step
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stepCnt <= '0;
        end else if (state == drs_pkg::S_UP || state == drs_pkg::S_DOWN) begin
            stepCnt <= stepEnd ? '0 : stepCnt + 1'b1;
        end else begin
            stepCnt <= '0;
        end
    end

    // Ramp counter: fixed integrate down to zero, then count de-integration
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rampCount <= 16'h0000;
        end else if (state == drs_pkg::S_READY && startReq) begin
            rampCount <= drs_pkg::RAMP_LOAD;
        end else if (state == drs_pkg::S_UP && stepEnd) begin
            rampCount <= rampCount - 16'h0001;
        end else if (state == drs_pkg::S_DOWN && stepEnd && comp
                     && rampCount != 16'hffff) begin
            rampCount <= rampCount + 16'h0001;
        end
    end

    // Visible result; saturates at full scale when out of range
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            overrange  <= 1'b0;
            resultHigh <= 4'h0;
            resultLow  <= 8'h00;
        end else if (state == drs_pkg::S_DONE) begin
            overrange <= isOver(rampCount);
            if (isOver(rampCount)) begin
                {resultHigh, resultLow} <= drs_pkg::MAX_RESULT[11:0];
            end else begin
                {resultHigh, resultLow} <= 12'(offsetFix(rampCount));
            end
        end
    end

    // Bus slave: one wait cycle per access, then a single accept cycle
    assign accWrite = write && !waitrequest;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    // Read data is settled during the wait cycle and held for the accept edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            case (address)
                drs_pkg::OFS_CTRL:     readdata <= {31'h0, softReq};
                drs_pkg::OFS_STATUS:   readdata <= {27'h0, state != drs_pkg::S_READY,
                                                    comp, rampSelectOutput,
                                                    overrange, convFinished};
                drs_pkg::OFS_RESULT:   readdata <= {20'h0, resultHigh, resultLow};
                drs_pkg::OFS_IRQ_STAT: readdata <= {30'h0, irqStatus};
                drs_pkg::OFS_IRQ_EN:   readdata <= {30'h0, irqEnable};
                default:               readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software cycle request; a new write wins over consumption
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            softReq <= 1'b0;
        end else if (accWrite && address == drs_pkg::OFS_CTRL
                     && writedata[drs_pkg::CTRL_CYCLE]) begin
            softReq <= 1'b1;
        end else if (state == drs_pkg::S_READY) begin
            softReq <= 1'b0;
        end
    end

    // Interrupt events, clear strobe and enable
    assign irqEvent[drs_pkg::IRQ_DONE] = state == drs_pkg::S_DONE;
    assign irqEvent[drs_pkg::IRQ_OVR]  = state == drs_pkg::S_DONE && isOver(rampCount);
    assign irqClear = (accWrite && address == drs_pkg::OFS_IRQ_CLR)
                      ? writedata[drs_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqEnable <= '0;
        end else if (accWrite && address == drs_pkg::OFS_IRQ_EN) begin
            irqEnable <= writedata[drs_pkg::IRQ_W-1:0];
        end
    end

    // Sticky status: an event in the clearing cycle survives
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= '0;
        end else begin
            irqStatus <= (irqStatus & ~irqClear) | irqEvent;
        end
    end

    // Registered level output; lags status by one cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqEnable);
        end
    end

    // Checks on the sequencer
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_start;
        state == drs_pkg::S_READY && startReq;
    endsequence

    sequence s_upEnd;
        state == drs_pkg::S_UP && stepEnd && rampCount == 16'h0001;
    endsequence

    sequence s_downEnd;
        state == drs_pkg::S_DOWN && stepEnd && !comp;
    endsequence

    property p_checkHigh;
        state == drs_pkg::S_CHECK |-> rampSelectOutput && !convFinished;
    endproperty
    a_checkHigh: assert property (p_checkHigh)
        else $error("ramp-select low or finished high during check");

    property p_readyFlags;
        state == drs_pkg::S_READY |-> convFinished && rampSelectOutput;
    endproperty
    a_readyFlags: assert property (p_readyFlags)
        else $error("ready without finished and ramp-select high");

    property p_start;
        s_start |=> state == drs_pkg::S_CROSS && !convFinished
                    && !rampSelectOutput && rampCount == drs_pkg::RAMP_LOAD;
    endproperty
    a_start: assert property (p_start)
        else $error("conversion start did not load counter and drop lines");

    property p_holdBeforeCross;
        state == drs_pkg::S_CROSS |=> rampCount == drs_pkg::RAMP_LOAD;
    endproperty
    a_holdBeforeCross: assert property (p_holdBeforeCross)
        else $error("counter moved before comparator crossing");

    property p_upDec;
        state == drs_pkg::S_UP && stepEnd |=> rampCount == $past(rampCount) - 16'h0001;
    endproperty
    a_upDec: assert property (p_upDec)
        else $error("ramp-up step did not decrement");

    property p_turnDown;
        s_upEnd |=> state == drs_pkg::S_DOWN && rampSelectOutput && rampCount == 16'h0000;
    endproperty
    a_turnDown: assert property (p_turnDown)
        else $error("counter zero did not raise ramp-select");

    property p_downInc;
        state == drs_pkg::S_DOWN && stepEnd && comp && rampCount != 16'hffff
            |=> rampCount == $past(rampCount) + 16'h0001;
    endproperty
    a_downInc: assert property (p_downInc)
        else $error("ramp-down step did not increment");

    property p_ratio;
        state == drs_pkg::S_DOWN && stepEnd
            |-> (int'(stepCnt) + 1) == drs_pkg::STEP_RATIO * UP_STEP_CYC;
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ramp-down step not twice ramp-up step");

    property p_finish;
        s_downEnd |=> state == drs_pkg::S_DONE ##1 state == drs_pkg::S_READY
                      && convFinished && rampSelectOutput;
    endproperty
    a_finish: assert property (p_finish)
        else $error("comparator return did not finish conversion");

    property p_result;
        state == drs_pkg::S_DONE && !isOver(rampCount)
            |=> {resultHigh, resultLow} == 12'(offsetFix($past(rampCount))) && !overrange;
    endproperty
    a_result: assert property (p_result)
        else $error("result not offset-corrected count");

    property p_over;
        state == drs_pkg::S_DONE && isOver(rampCount)
            |=> overrange && convFinished && rampSelectOutput;
    endproperty
    a_over: assert property (p_over)
        else $error("overrange not flagged");

    property p_hold;
        state != drs_pkg::S_DONE
            |=> $stable(resultHigh) && $stable(resultLow) && $stable(overrange);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed outside completion");

    property p_bus;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus accept cycle malformed");
endmodule // drs_sequencer
`default_nettype wire

// [hdl/drs_pkg.sv]
// Constants shared by the dual ramp sequencer: timing, counts, register map.
// Assumes a 50 MHz system clock; all counts derive from the figures below.
package drs_pkg;
    // Clock and step timing
    localparam int CLK_NS      = 20;
    localparam int REF_CLK_HZ  = 1_000_000;
    localparam int STEP_RATIO  = 2;        // Ramp-down step over ramp-up step
    localparam int UP_STEP_NS  = 10_000;
    localparam int DN_STEP_NS  = UP_STEP_NS * STEP_RATIO;
    localparam int UP_STEP_CYC = UP_STEP_NS / CLK_NS;
    localparam int DN_STEP_CYC = DN_STEP_NS / CLK_NS;
    localparam int FULL_SCALE_MS = 165;    // Nominal at the reference rate
    localparam int STEP_W      = 10;
    // Counts
    localparam logic [15:0] RAMP_LOAD     = 16'h2000;
    localparam logic [15:0] OFFSET_COUNTS = 16'h0200;
    localparam logic [15:0] MAX_RESULT    = 16'h0fff;
    // Pin bit positions inside the synchroniser
    localparam int PIN_W     = 2;
    localparam int PIN_COMP  = 0;
    localparam int PIN_CYCLE = 1;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_STATUS   = 5'h04;
    localparam logic [4:0] OFS_RESULT   = 5'h08;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
    localparam logic [4:0] OFS_IRQ_CLR  = 5'h10;
    localparam logic [4:0] OFS_IRQ_EN   = 5'h14;
    // Field positions
    localparam int CTRL_CYCLE = 0;
    localparam int STAT_FIN   = 0;
    localparam int STAT_OVR   = 1;
    localparam int STAT_RAMP  = 2;
    localparam int STAT_COMP  = 3;
    localparam int STAT_BUSY  = 4;
    localparam int IRQ_W      = 2;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_OVR    = 1;
    // Sequencer states
    typedef enum logic [2:0] {
        S_CHECK = 3'b000,
        S_READY = 3'b001,
        S_CROSS = 3'b010,
        S_UP    = 3'b011,
        S_DOWN  = 3'b100,
        S_DONE  = 3'b101
    } drs_state_t;
endpackage

// [hdl/drs_pin_if.sv]
// Carries raw pin levels into the synchroniser and clean levels back out.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface drs_pin_if;
    logic [drs_pkg::PIN_W-1:0] pinRaw;
    logic [drs_pkg::PIN_W-1:0] pinClean;
    modport sync (input pinRaw, output pinClean);
    modport core (output pinRaw, input pinClean);
endinterface
`default_nettype wire

// [hdl/drs_pin_sync.sv]
// Three-stage synchroniser for the asynchronous comparator and cycle pins.
// Assumes pins are unrelated to clk_sys; a change counts once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module drs_pin_sync (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    drs_pin_if.sync   pins
);
    logic [drs_pkg::PIN_W-1:0] stage1;
    logic [drs_pkg::PIN_W-1:0] stage2;
    logic [drs_pkg::PIN_W-1:0] stage3;
    logic [drs_pkg::PIN_W-1:0] clean;

    // Shift chain; stage1 feeds only stage2 to keep metastability contained
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pins.pinRaw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a new level only where the two settled stages agree
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clean <= '0;
        end else begin
            clean <= (~(stage2 ^ stage3) & stage2) | ((stage2 ^ stage3) & clean);
        end
    end

    assign pins.pinClean = clean;
endmodule // drs_pin_sync
`default_nettype wire

// [sim/drs_analog_model.sv]
// Behavioural integrator, comparator and reference facing the dual ramp sequencer.
// Assumes the bench sets the input level and may pin the comparator high on purpose.
`timescale 1ns/1ps
`default_nettype none
module drs_analog_model #(
    parameter int DEC = 4096
) (
    input  wire logic               clk_sys,
    input  wire logic               rampSelectOutput,
    input  wire logic signed [15:0] vinCode,
    input  wire logic               stuckHigh,
    output logic                    comparatorInput
);
    logic signed [31:0] level = -32'sd4096;
    logic signed [31:0] next_level;

    // Reference pulls down; clamp below threshold so a long idle does not store charge
    assign next_level = level - DEC;

    // Input plus offset current charges while ramp-select is low, reference discharges otherwise
    always_ff @(posedge clk_sys) begin
        if (!rampSelectOutput) begin
            level <= level + vinCode + 32'sd512;
        end else begin
            level <= (next_level < -32'sd4096) ? -32'sd4096 : next_level;
        end
    end

    // High while above threshold; stuckHigh models an integrator that will not settle
    assign comparatorInput = stuckHigh | (level > 0);
endmodule // drs_analog_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench: Avalon register tasks, pin requests, three conversions.
// Assumes short step parameters (2 and 4 cycles) so a conversion is about 18k to 35k cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               clk_sys;
    logic               reset_n;
    logic        [4:0]  address;
    logic               read;
    logic               write;
    logic        [31:0] writedata;
    logic        [31:0] readdata;
    logic               waitrequest;
    logic               cycleRequestInput;
    logic               comparatorInput;
    logic               rampSelectOutput;
    logic               convFinished;
    logic               overrange;
    logic        [3:0]  resultHigh;
    logic        [7:0]  resultLow;
    logic               irq;
    logic signed [15:0] vinCode;
    logic               stuckHigh;
    logic        [31:0] rdv;
    int                 n_fail;
    int                 tests_run;

    drs_sequencer #(.UP_STEP_CYC(2), .DN_STEP_CYC(4), .STEP_W(drs_pkg::STEP_W)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cycleRequestInput(cycleRequestInput), .comparatorInput(comparatorInput),
        .rampSelectOutput(rampSelectOutput), .convFinished(convFinished), .overrange(overrange),
        .resultHigh(resultHigh), .resultLow(resultLow), .irq(irq));

    drs_analog_model #(.DEC(4096)) model (
        .clk_sys(clk_sys), .rampSelectOutput(rampSelectOutput), .vinCode(vinCode),
        .stuckHigh(stuckHigh), .comparatorInput(comparatorInput));

    // 50 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Unknowns fall to 0, so an X never lands inside the window
    function automatic logic [31:0] inr(input logic [31:0] v, input int lo, input int hi);
        inr = 32'h0;
        if (v >= lo && v <= hi) inr = 32'h1;
    endfunction

    // One Avalon access, entered just after a rising edge; one idle edge after release
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        i = 0;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk_sys);
            i++;
        end while (waitrequest !== 1'b0 && i < 100);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (i >= 100) chk(32'h0, 32'h1);
        @(posedge clk_sys);
    endtask

    // Request, then time ramp-up and ramp-down; prior result must hold meanwhile
    task automatic conv(input logic signed [15:0] v, input logic useCtrl, input int plo, input int phi,
                        input logic po, input int rlo, input int rhi, input logic ro, input int dnExp);
        int i;
        i = 0;
        vinCode <= v;
        if (useCtrl) bus(1'b1, drs_pkg::OFS_CTRL, 32'h1, rdv);
        else cycleRequestInput <= 1'b1;
        while (rampSelectOutput !== 1'b0 && i < 20) begin
            @(posedge clk_sys);
            i++;
        end
        chk(convFinished, 1'b0);
        cycleRequestInput <= 1'b0;
        chk(inr({resultHigh, resultLow}, plo, phi), 32'h1);
        chk(overrange, po);
        i = 0;
        while (rampSelectOutput === 1'b0 && i < 20000) begin
            @(posedge clk_sys);
            i++;
        end
        chk(inr(i, 16384, 16410), 32'h1);
        i = 0;
        while (convFinished !== 1'b1 && i < 30000) begin
            @(posedge clk_sys);
            i++;
        end
        chk(inr(i, dnExp - 8, dnExp + 32), 32'h1);
        chk(inr({resultHigh, resultLow}, rlo, rhi), 32'h1);
        chk(overrange, ro);
        chk(rampSelectOutput, 1'b1);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Three conversions of about 18k to 35k cycles each, plus margin
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        results();
    end

    initial begin
        reset_n = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        cycleRequestInput = 1'b0;
        vinCode = 16'sd0;
        stuckHigh = 1'b1;
        n_fail = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_sys);
        chk({waitrequest, irq, overrange, convFinished, rampSelectOutput}, 32'h11);
        chk({resultHigh, resultLow}, 32'h0);
        reset_n <= 1'b1;
        // Integrator held above threshold: no ready flag may appear
        repeat (20) @(posedge clk_sys);
        chk({convFinished, rampSelectOutput}, 32'h1);
        stuckHigh <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(convFinished, 1'b1);
        bus(1'b0, drs_pkg::OFS_STATUS, 32'h0, rdv);
        chk(rdv, 32'h5);
        bus(1'b1, 5'h18, 32'hffff_ffff, rdv);
        bus(1'b0, 5'h18, 32'h0, rdv);
        chk(rdv, 32'h0);
        bus(1'b1, drs_pkg::OFS_IRQ_EN, 32'h0, rdv);
        conv(16'sd1000, 1'b0, 0, 0, 1'b0, 999, 1006, 1'b0, 6048);
        bus(1'b0, drs_pkg::OFS_IRQ_STAT, 32'h0, rdv);
        chk(rdv, 32'h1);
        chk(irq, 1'b0);
        bus(1'b1, drs_pkg::OFS_IRQ_EN, 32'h3, rdv);
        // The level output trails status and enable by one registered cycle
        @(posedge clk_sys);
        chk(irq, 1'b1);
        bus(1'b1, drs_pkg::OFS_IRQ_CLR, 32'h1, rdv);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        conv(16'sd4200, 1'b1, 999, 1006, 1'b0, 4095, 4095, 1'b1, 18848);
        repeat (2) @(posedge clk_sys);
        chk(irq, 1'b1);
        bus(1'b0, drs_pkg::OFS_IRQ_STAT, 32'h0, rdv);
        chk(rdv, 32'h3);
        bus(1'b0, drs_pkg::OFS_IRQ_CLR, 32'h0, rdv);
        chk(rdv, 32'h0);
        bus(1'b1, drs_pkg::OFS_IRQ_CLR, 32'h3, rdv);
        bus(1'b0, drs_pkg::OFS_IRQ_EN, 32'h0, rdv);
        chk(rdv, 32'h3);
        chk(irq, 1'b0);
        conv(-16'sd100, 1'b0, 4095, 4095, 1'b1, 0, 0, 1'b0, 1648);
        results();
    end
endmodule // tb
`default_nettype wire
